/* rtl/uart_shadow_consts.svh */
`ifndef UART_SHADOW_CONSTS_SVH
`define UART_SHADOW_CONSTS_SVH

// Register byte addresses within the peripheral window.
`define RX_FIFO_LEVEL_ADDR 32'h5000_1184
`define SOFT_RESET_SHADOW_ADDR 32'h5000_1188
`define REQUEST_TO_SEND_SHADOW_ADDR 32'h5000_118C
// Extra control and status registers for the loose bits.
`define MODEM_CONTROL_ADDR 32'h5000_11A0
`define FIFO_CONTROL_ADDR 32'h5000_11A4
`define STATUS_ADDR 32'h5000_11A8

// Soft reset register fields.
`define TX_FIFO_CLEAR_BIT 2
`define RX_FIFO_CLEAR_BIT 1
`define CONTROLLER_RESET_BIT 0
// Modem control fields.
`define MCR_RTS_BIT 1
`define MCR_LOOPBACK_BIT 4
`define MCR_AUTO_FLOW_BIT 5
`define MCR_WIDTH 6
// FIFO control fields.
`define FCR_FIFO_ENABLE_BIT 0
// Status fields.
`define STAT_CTRL_RESET_BIT 0
`define STAT_LOOP_RTS_BIT 1
`define STAT_THRESH_BIT 2

`define REG_RESET_VALUE 16'h0000
`define CTRL_RESET_CYCLES 2

`endif

/* rtl/uart_shadow_pkg.sv */
package uart_shadow_pkg;
    typedef logic [15:0] half_t;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_e;
endpackage

/* rtl/uart_shadow_regs.sv */
`include "uart_shadow_consts.svh"
// Behaviour
// - Read-only 16-bit field shows current receive FIFO entry count.
// - Writing one to tx_fifo_clear_bit pulses transmit FIFO reset; self-clearing.
// - Writing one to rx_fifo_clear_bit pulses receive FIFO reset; self-clearing.
// - Transmit clear mirrors fifo_control_register bit 2 without rewriting it.
// - controller_reset_bit asserts controller reset at once, releases on clock.
// - Controller reset covers both bus and serial clock domain logic.
// - rts_shadow_bit and modem_control_register RTS bit share one state.
// - Without auto flow or loopback, rts_n is low whenever the RTS bit is high.
// - Auto flow with FIFOs enabled also gates RTS by the threshold.
// - Under auto flow with FIFOs enabled, rts_n is high while FIFO fill exceeds threshold.
// - Loopback holds rts_n high and routes RTS bit to a modem input.
module uart_shadow_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire uart_shadow_pkg::word_t wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire uart_shadow_pkg::word_t wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire uart_shadow_pkg::half_t rx_level_i,
    input wire logic rx_thresh_i,
    output logic tx_fifo_clear_o,
    output logic rx_fifo_clear_o,
    output logic ctrl_reset_o,
    output logic rts_n_o,
    output logic loop_rts_o
);
    import uart_shadow_pkg::*;

    typedef struct packed {
        bus_state_e st;
        word_t dat;
        logic ack;
        logic [`MCR_WIDTH-1:0] modem_control_register;
        logic fifo_en;
        logic txclr;
        logic rxclr;
        logic [1:0] rcnt;
        logic creset;
        logic rts_n;
        logic loop_rts;
        logic thr1;
        logic thr2;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic soft_rst;
    logic wr;
    logic rd;
    logic rts_bit;
    logic afc;
    logic loopb;

    function automatic logic hit(input word_t a, input word_t b);
        hit = (a[31:2] == b[31:2]);
    endfunction

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && s_r.st == BUS_IDLE;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && s_r.st == BUS_IDLE;
    // Controller reset acts as soon as the write is presented, before any clock edge.
    assign soft_rst = wr && wb_sel_i[0]
        && hit(wb_adr_i, `SOFT_RESET_SHADOW_ADDR)
        && wb_dat_i[`CONTROLLER_RESET_BIT];

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.txclr = 1'b0;
        s_nxt.rxclr = 1'b0;
        s_nxt.thr1 = rx_thresh_i;
        s_nxt.thr2 = s_r.thr1;
        if (s_r.rcnt != 2'd0) begin
            s_nxt.rcnt = s_r.rcnt - 2'd1;
        end
        // The controller reset output is a flop of its own, so the pin
        // carries no decode glitch when the count runs out.
        s_nxt.creset = s_nxt.rcnt != 2'd0;
        unique case (s_r.st)
            BUS_IDLE: begin
                if (wr || rd) begin
                    s_nxt.st = BUS_ACK;
                    s_nxt.ack = 1'b1;
                    s_nxt.dat = 32'h0000_0000;
                end
                if (rd) begin
                    if (hit(wb_adr_i, `RX_FIFO_LEVEL_ADDR)) begin
                        s_nxt.dat[15:0] = rx_level_i;
                    end else if (hit(wb_adr_i,
                            `REQUEST_TO_SEND_SHADOW_ADDR)) begin
                        s_nxt.dat[0] = s_r.modem_control_register[`MCR_RTS_BIT];
                    end else if (hit(wb_adr_i, `MODEM_CONTROL_ADDR)) begin
                        s_nxt.dat[`MCR_WIDTH-1:0] = s_r.modem_control_register;
                    end else if (hit(wb_adr_i, `FIFO_CONTROL_ADDR)) begin
                        s_nxt.dat[0] = s_r.fifo_en;
                    end else if (hit(wb_adr_i, `STATUS_ADDR)) begin
                        s_nxt.dat[`STAT_CTRL_RESET_BIT] = s_r.creset;
                        s_nxt.dat[`STAT_LOOP_RTS_BIT] = s_r.loop_rts;
                        s_nxt.dat[`STAT_THRESH_BIT] = s_r.thr2;
                    end
                    // Soft reset register and unmapped reads give zero.
                end
                if (wr && wb_sel_i[0]) begin
                    if (hit(wb_adr_i, `SOFT_RESET_SHADOW_ADDR)) begin
                        s_nxt.txclr = wb_dat_i[`TX_FIFO_CLEAR_BIT];
                        s_nxt.rxclr = wb_dat_i[`RX_FIFO_CLEAR_BIT];
                    end else if (hit(wb_adr_i,
                            `REQUEST_TO_SEND_SHADOW_ADDR)) begin
                        s_nxt.modem_control_register[`MCR_RTS_BIT] = wb_dat_i[0];
                    end else if (hit(wb_adr_i, `MODEM_CONTROL_ADDR)) begin
                        s_nxt.modem_control_register = wb_dat_i[`MCR_WIDTH-1:0];
                    end else if (hit(wb_adr_i, `FIFO_CONTROL_ADDR)) begin
                        s_nxt.fifo_en = wb_dat_i[`FCR_FIFO_ENABLE_BIT];
                        s_nxt.txclr = wb_dat_i[`TX_FIFO_CLEAR_BIT];
                        s_nxt.rxclr = wb_dat_i[`RX_FIFO_CLEAR_BIT];
                    end
                end
            end
            BUS_ACK: begin
                s_nxt.st = BUS_IDLE;
            end
        endcase
        rts_bit = s_nxt.modem_control_register[`MCR_RTS_BIT];
        afc = s_nxt.modem_control_register[`MCR_AUTO_FLOW_BIT] && s_nxt.fifo_en;
        loopb = s_nxt.modem_control_register[`MCR_LOOPBACK_BIT];
        if (loopb) begin
            s_nxt.rts_n = 1'b1;
        end else if (afc) begin
            s_nxt.rts_n = !(rts_bit && !s_r.thr2);
        end else begin
            s_nxt.rts_n = !rts_bit;
        end
        s_nxt.loop_rts = loopb && rts_bit;
    end

    // Reset images. The soft one raises the controller reset, both FIFO
    // clears and the acknowledge at once, so the master still completes
    // the write that caused it. The image holds until the master lets go,
    // and the count then runs out at the next edge, which drops the controller reset.
    localparam state_s SOFT_RESET_STATE = '{
        st: BUS_IDLE,
        dat: 32'h0000_0000,
        ack: 1'b1,
        modem_control_register: '0,
        fifo_en: 1'b0,
        txclr: 1'b1,
        rxclr: 1'b1,
        rcnt: 2'(`CTRL_RESET_CYCLES - 1),
        creset: 1'b1,
        rts_n: 1'b1,
        loop_rts: 1'b0,
        thr1: 1'b0,
        thr2: 1'b0
    };
    localparam state_s BUS_RESET_STATE = '{
        st: BUS_IDLE,
        dat: 32'h0000_0000,
        ack: 1'b0,
        modem_control_register: '0,
        fifo_en: 1'b0,
        txclr: 1'b0,
        rxclr: 1'b0,
        rcnt: 2'h0,
        creset: 1'b0,
        rts_n: 1'b1,
        loop_rts: 1'b0,
        thr1: 1'b0,
        thr2: 1'b0
    };

    // The stretched pulse resets both clock domains of the controller.
    always_ff @(posedge clk_i or posedge soft_rst) begin
        if (soft_rst) begin
            s_r <= SOFT_RESET_STATE;
        end else if (rst_i) begin
            s_r <= BUS_RESET_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign tx_fifo_clear_o = s_r.txclr;
    assign rx_fifo_clear_o = s_r.rxclr;
    assign ctrl_reset_o = s_r.creset;
    assign rts_n_o = s_r.rts_n;
    assign loop_rts_o = s_r.loop_rts;

    // FIFO clears last one cycle, or two while the controller is in reset.
    clear_pulse_a: assert property (@(posedge clk_i)
        disable iff (rst_i || ctrl_reset_o)
        s_r.txclr |=> !s_r.txclr)
        else $error("transmit clear did not self clear");

    rx_self_a: assert property (@(posedge clk_i)
        disable iff (rst_i || ctrl_reset_o)
        s_r.rxclr |=> !s_r.rxclr)
        else $error("receive clear did not self clear");

    tx_clear_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wr && wb_sel_i[0] && hit(wb_adr_i, `SOFT_RESET_SHADOW_ADDR)
        && wb_dat_i[`TX_FIFO_CLEAR_BIT] && !soft_rst) |=> tx_fifo_clear_o
        ##1 !tx_fifo_clear_o)
        else $error("transmit clear pulse wrong");

    rx_clear_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wr && wb_sel_i[0] && hit(wb_adr_i, `SOFT_RESET_SHADOW_ADDR)
        && wb_dat_i[`RX_FIFO_CLEAR_BIT] && !soft_rst) |=> rx_fifo_clear_o
        ##1 !rx_fifo_clear_o)
        else $error("receive clear pulse wrong");

    fcr_shadow_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wr && wb_sel_i[0] && hit(wb_adr_i, `FIFO_CONTROL_ADDR)
        && wb_dat_i[`TX_FIFO_CLEAR_BIT]) |=> tx_fifo_clear_o)
        else $error("fifo control clear not passed on");

    fcr_kept_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wr && hit(wb_adr_i, `SOFT_RESET_SHADOW_ADDR) && !soft_rst)
        |=> s_r.fifo_en == $past(s_r.fifo_en)
        && s_r.modem_control_register == $past(s_r.modem_control_register))
        else $error("fifo clear disturbed other settings");

    // Register reads answer one cycle after the request is taken.
    level_read_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (rd && hit(wb_adr_i, `RX_FIFO_LEVEL_ADDR)) |=>
        wb_dat_o == {16'h0000, $past(rx_level_i)})
        else $error("level read mismatch");

    level_zero_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (rd && hit(wb_adr_i, `RX_FIFO_LEVEL_ADDR)) |=>
        wb_dat_o[31:16] == 16'h0000)
        else $error("level read upper half not zero");

    srr_read_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (rd && hit(wb_adr_i, `SOFT_RESET_SHADOW_ADDR)) |=>
        wb_dat_o == 32'h0000_0000)
        else $error("soft reset read not zero");

    srts_read_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (rd && hit(wb_adr_i, `REQUEST_TO_SEND_SHADOW_ADDR)) |=>
        wb_dat_o == {31'h0000_0000, $past(s_r.modem_control_register[`MCR_RTS_BIT])})
        else $error("shadow rts read mismatch");

    mcr_read_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (rd && hit(wb_adr_i, `MODEM_CONTROL_ADDR)) |=>
        wb_dat_o == {26'h000_0000, $past(s_r.modem_control_register)})
        else $error("modem control read mismatch");

    shadow_same_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wr && wb_sel_i[0] && hit(wb_adr_i, `REQUEST_TO_SEND_SHADOW_ADDR)
        && !soft_rst) |=> s_r.modem_control_register[`MCR_RTS_BIT] == $past(wb_dat_i[0]))
        else $error("shadow rts not stored");

    // The pin level is registered from the same next-state modem control
    // bits, so it lines up with the stored bits at every edge.
    loop_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_r.modem_control_register[`MCR_LOOPBACK_BIT] |-> rts_n_o)
        else $error("rts_n low in loopback");

    loop_route_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_r.modem_control_register[`MCR_LOOPBACK_BIT] |-> loop_rts_o == s_r.modem_control_register[`MCR_RTS_BIT])
        else $error("looped rts value wrong");

    no_loop_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !s_r.modem_control_register[`MCR_LOOPBACK_BIT] |-> !loop_rts_o)
        else $error("looped rts outside loopback");

    manual_rts_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!s_r.modem_control_register[`MCR_LOOPBACK_BIT] && !s_r.modem_control_register[`MCR_AUTO_FLOW_BIT])
        |-> rts_n_o == !s_r.modem_control_register[`MCR_RTS_BIT])
        else $error("rts_n not following bit");

    flow_gate_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ($past(s_r.thr2) && !s_r.modem_control_register[`MCR_LOOPBACK_BIT] && s_r.fifo_en
        && s_r.modem_control_register[`MCR_AUTO_FLOW_BIT])
        |-> rts_n_o)
        else $error("rts_n low above threshold");

    flow_open_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!$past(s_r.thr2) && !s_r.modem_control_register[`MCR_LOOPBACK_BIT] && s_r.fifo_en
        && s_r.modem_control_register[`MCR_AUTO_FLOW_BIT])
        |-> rts_n_o == !s_r.modem_control_register[`MCR_RTS_BIT])
        else $error("rts_n not following bit below threshold");

    flow_nofifo_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!s_r.modem_control_register[`MCR_LOOPBACK_BIT] && !s_r.fifo_en
        && s_r.modem_control_register[`MCR_AUTO_FLOW_BIT])
        |-> rts_n_o == !s_r.modem_control_register[`MCR_RTS_BIT])
        else $error("threshold gated rts with fifos off");

    thresh_sync_a: assert property (@(posedge clk_i)
        disable iff (rst_i || ctrl_reset_o)
        s_r.thr2 == $past(s_r.thr1))
        else $error("threshold synchroniser skipped a stage");

    // Controller reset: up at once on the write, held for two edges.
    reset_len_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(ctrl_reset_o) |-> ctrl_reset_o [*2] ##1 !ctrl_reset_o)
        else $error("controller reset length wrong");

    soft_ack_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        soft_rst |-> wb_ack_o && ctrl_reset_o)
        else $error("soft reset not applied at once");

    soft_clear_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ctrl_reset_o |-> tx_fifo_clear_o && rx_fifo_clear_o)
        else $error("fifo clears missing under controller reset");

    soft_rts_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ctrl_reset_o |-> rts_n_o && !loop_rts_o
        && s_r.modem_control_register == '0 && !s_r.fifo_en)
        else $error("control state kept under controller reset");

endmodule

/* test/modem_model.sv */
module modem_model (
    input wire logic clk_i,
    input wire logic rts_n_i,
    output uart_shadow_pkg::half_t sent_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import uart_shadow_pkg::*;
    // The data set sends one character per cycle while it is asked to.
    initial sent_o = 16'h0000;
    always @(posedge clk_i) begin
        if (rts_n_i === 1'b0)
            sent_o <= sent_o + 16'h0001;
    end
endmodule

/* test/tb.sv */
`include "uart_shadow_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uart_shadow_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    word_t wb_adr_i = 0, wb_dat_i = 0, rd;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_o;
    half_t rx_level_i = 0, sent, snap;
    logic rx_thresh_i = 0, wb_ack_o, tx_fifo_clear_o, rx_fifo_clear_o;
    logic ctrl_reset_o, rts_n_o, loop_rts_o, tc, rc, cr;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    uart_shadow_regs uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_level_i(rx_level_i),
        .rx_thresh_i(rx_thresh_i), .tx_fifo_clear_o(tx_fifo_clear_o),
        .rx_fifo_clear_o(rx_fifo_clear_o), .ctrl_reset_o(ctrl_reset_o),
        .rts_n_o(rts_n_o), .loop_rts_o(loop_rts_o));
    modem_model modem (.clk_i(clk_i), .rts_n_i(rts_n_o), .sent_o(sent));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict;
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task wb(input logic we, input word_t a, input word_t d);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        tc = tx_fifo_clear_o;
        rc = rx_fifo_clear_o;
        cr = ctrl_reset_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk_i);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    initial begin
        tick(8);
        rst_i <= 0;
        rx_level_i <= 16'hA5C3;
        tick(2);
        wb(0, `RX_FIFO_LEVEL_ADDR, 0);
        chk("level", rd, 32'h0000_A5C3);
        chk("rts_rst", rts_n_o, 1'b1);
        wb(0, `SOFT_RESET_SHADOW_ADDR, 0);
        chk("srr_rd", rd, 32'h0000_0000);
        wb(1, `REQUEST_TO_SEND_SHADOW_ADDR, 32'hFFFF_FFFF);
        wb(0, `REQUEST_TO_SEND_SHADOW_ADDR, 0);
        chk("srts_rd", rd, 32'h0000_0001);
        wb(0, `MODEM_CONTROL_ADDR, 0);
        chk("mcr_rts", rd, 32'h0000_0002);
        wb(0, 32'h5000_11B0, 0);
        chk("unmapped", rd, 32'h0000_0000);
        tick(2);
        chk("rts_on", rts_n_o, 1'b0);
        snap = sent;
        tick(2);
        chk("rts_sent", sent - snap, 32'h0000_0002);
        $display("test access done");
        wb(1, `MODEM_CONTROL_ADDR, 32'h0000_0022);
        wb(1, `FIFO_CONTROL_ADDR, 32'h0000_0001);
        rx_thresh_i <= 1;
        tick(5);
        chk("rts_full", rts_n_o, 1'b1);
        rx_thresh_i <= 0;
        tick(5);
        chk("rts_below", rts_n_o, 1'b0);
        rx_thresh_i <= 1;
        wb(1, `FIFO_CONTROL_ADDR, 32'h0000_0000);
        tick(5);
        chk("rts_nofifo", rts_n_o, 1'b0);
        $display("test flow done");
        wb(1, `FIFO_CONTROL_ADDR, 32'h0000_0001);
        wb(1, `SOFT_RESET_SHADOW_ADDR, 32'h0000_0004);
        chk("txclr", tc, 1'b1);
        chk("txclr_rx", rc, 1'b0);
        chk("txclr_self", tx_fifo_clear_o, 1'b0);
        tick(4);
        chk("fcr_kept", rts_n_o, 1'b1);
        wb(1, `SOFT_RESET_SHADOW_ADDR, 32'h0000_0002);
        chk("rxclr", rc, 1'b1);
        chk("rxclr_self", rx_fifo_clear_o, 1'b0);
        wb(1, `FIFO_CONTROL_ADDR, 32'h0000_0005);
        chk("fcr_txclr", tc, 1'b1);
        $display("test clear done");
        rx_thresh_i <= 0;
        wb(1, `MODEM_CONTROL_ADDR, 32'h0000_0012);
        tick(4);
        snap = sent;
        tick(8);
        chk("loop_rts_n", rts_n_o, 1'b1);
        chk("loop_rts", loop_rts_o, 1'b1);
        chk("loop_sent", sent, snap);
        wb(0, `STATUS_ADDR, 0);
        chk("stat_loop", rd[1], 1'b1);
        $display("test loop done");
        wb(1, `SOFT_RESET_SHADOW_ADDR, 32'h0000_0001);
        chk("ctrl_rst", cr, 1'b1);
        chk("rst_tx", tc, 1'b1);
        chk("rst_rx", rc, 1'b1);
        tick(4);
        chk("ctrl_rel", ctrl_reset_o, 1'b0);
        chk("rst_loop", loop_rts_o, 1'b0);
        wb(0, `MODEM_CONTROL_ADDR, 0);
        chk("rst_mcr", rd, 32'h0000_0000);
        $display("test reset done");
        print_verdict;
    end
endmodule
